// file: rx_descriptor_ring_manager.sv
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/10ps
module rx_descriptor_ring_manager (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rx_ring_pkg::rx_byte_s rx_i,
    output logic rx_ready_o,
    output rx_ring_pkg::mem_req_s mem_o,
    input wire rx_ring_pkg::mem_rsp_s mem_i
);
    import rx_ring_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_RECV, ST_STORE, ST_WB} state_e;

    state_e state_q;
    logic [31:4] base_low_q;
    logic [31:0] base_high_q;
    logic [20:7] len_q;
    logic [15:0] head_q;
    logic [15:0] shadow_q;
    logic [15:0] tail_q;
    logic ext_status_q;
    logic [1:0] dtyp_q;
    logic vlan_strip_q;
    logic [7:0] csum_start_q;
    logic [63:0] buf_addr_q;
    logic [15:0] cnt_q;
    logic [15:0] pos_q;
    logic [15:0] csum_q;
    logic last_q;
    logic pif_q;
    logic [3:0] npend_q;
    logic [3:0] wb_idx_q;
    logic [15:0] pend_len_q [PEND_DEPTH];
    logic wb_hit;
    logic byte_done;
    logic close_d;
    logic [16:0] ring_count;
    logic [16:0] step;
    logic avail;
    logic [15:0] shadow_nxt;
    logic [15:0] head_nxt;
    logic strip_byte;
    logic [15:0] rel_pos;
    logic [16:0] csum_sum;

    ////////////////////////////////////////////////////////////////////////////////
    // ring arithmetic

    function automatic logic [63:0] desc_addr(input logic [15:0] idx);
        desc_addr = {base_high_q, base_low_q, 4'h0} + {44'h0, idx, 4'h0};
    endfunction : desc_addr

    function automatic logic [15:0] advance(input logic [15:0] idx);
        logic [16:0] nxt;
        nxt = {1'b0, idx} + step;
        advance = (nxt >= ring_count) ? 16'h0000 : nxt[15:0];
    endfunction : advance

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] val);
        for (int i = 0; i < 4; i++)
        begin
            lane_merge[i*8 +: 8] = wb_sel_i[i] ? val[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : lane_merge

    // legacy write-back word: length, checksum, status, errors, special
    function automatic logic [63:0] wb_word(input logic [3:0] i);
        logic [7:0] st;
        logic [15:0] cs;
        st = 8'h00;
        st[DSTAT_DONE] = 1'b1;
        st[DSTAT_IXSM] = 1'b1;
        st[DSTAT_EOP] = (i == npend_q - 4'h1);
        st[DSTAT_PIF] = pif_q;
        cs = (i == 4'h0) ? csum_q : 16'h0000;
        wb_word = {16'h0000, 8'h00, st, cs, pend_len_q[i[2:0]]};
    endfunction : wb_word

    // a layout other than legacy still gets legacy fields; only split without ext status takes a stride of two
    assign step = (dtyp_q == DTYP_SPLIT && !ext_status_q) ? STEP_SPLIT : STEP_LEGACY;
    assign ring_count = {len_q, 3'h0};
    assign shadow_nxt = advance(shadow_q);
    assign head_nxt = advance(head_q);
    // the device owns only what lies from the shadow head up to the tail
    assign avail = (shadow_q != tail_q) && (ring_count != 17'h00000);
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign byte_done = !mem_o.valid || mem_i.ack;
    assign close_d = last_q || (cnt_q == BUF_BYTES);
    assign strip_byte = vlan_strip_q && rx_i.vlan_hdr;
    assign rel_pos = pos_q - {8'h00, csum_start_q};
    assign csum_sum = {1'b0, csum_q} + (rel_pos[0] ? {9'h000, rx_i.data} : {1'b0, rx_i.data, 8'h00});

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack drops the cycle after

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= RESET_WORD;
        end
        else
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= RESET_WORD;
            if (wb_hit && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    REG_BASE_LOW: wb_dat_o <= {base_low_q, 4'h0};
                    REG_BASE_HIGH: wb_dat_o <= base_high_q;
                    REG_LENGTH: wb_dat_o <= {11'h000, len_q, 7'h00};
                    REG_HEAD: wb_dat_o <= {16'h0000, head_q};
                    REG_TAIL: wb_dat_o <= {16'h0000, tail_q};
                    REG_CONTROL: wb_dat_o <= {28'h0000000, vlan_strip_q, dtyp_q, ext_status_q};
                    REG_CSUM_CTRL: wb_dat_o <= {24'h000000, csum_start_q};
                    REG_STATUS: wb_dat_o <= {14'h0000, state_q != ST_IDLE || npend_q != 4'h0,
                        head_q == tail_q, shadow_q};
                    default: wb_dat_o <= RESET_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            base_low_q <= RESET_WORD[31:4];
            base_high_q <= RESET_WORD;
            len_q <= RESET_WORD[20:7];
            tail_q <= RESET_WORD[15:0];
            ext_status_q <= 1'b0;
            dtyp_q <= DTYP_LEGACY;
            vlan_strip_q <= 1'b0;
            csum_start_q <= RESET_WORD[7:0];
        end
        else if (wb_hit && wb_we_i)
        begin
            unique case (wb_adr_i)
                REG_BASE_LOW: base_low_q <= 28'(lane_merge({base_low_q, 4'h0}, wb_dat_i)
                    >> BASE_LSB);
                REG_BASE_HIGH: base_high_q <= lane_merge(base_high_q, wb_dat_i);
                REG_LENGTH: len_q <= 14'(lane_merge({11'h000, len_q, 7'h00}, wb_dat_i)
                    >> LEN_LSB);
                REG_TAIL: tail_q <= 16'(lane_merge({16'h0000, tail_q}, wb_dat_i));
                REG_CONTROL:
                begin
                    ext_status_q <= wb_sel_i[0] ? wb_dat_i[CTRL_EXT_STATUS] : ext_status_q;
                    dtyp_q <= wb_sel_i[0] ? wb_dat_i[CTRL_DTYP_LO +: 2] : dtyp_q;
                    vlan_strip_q <= wb_sel_i[0] ? wb_dat_i[CTRL_VLAN_STRIP] : vlan_strip_q;
                end
                REG_CSUM_CTRL: csum_start_q <= wb_sel_i[0] ? wb_dat_i[7:0] : csum_start_q;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // head and shadow head; software may move them only while nothing is pending

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            head_q <= RESET_WORD[15:0];
            shadow_q <= RESET_WORD[15:0];
        end
        else
        begin
            if (wb_hit && wb_we_i && wb_adr_i == REG_HEAD && state_q == ST_IDLE
                && npend_q == 4'h0)
            begin
                head_q <= 16'(lane_merge({16'h0000, head_q}, wb_dat_i));
                shadow_q <= 16'(lane_merge({16'h0000, head_q}, wb_dat_i));
            end
            else
            begin
                if (state_q == ST_STORE && byte_done && close_d)
                begin
                    shadow_q <= shadow_nxt;
                end
                if (state_q == ST_WB && mem_i.ack)
                begin
                    head_q <= head_nxt;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive state machine and memory master

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= ST_IDLE;
            mem_o <= '0;
            rx_ready_o <= 1'b0;
            buf_addr_q <= 64'h0000_0000_0000_0000;
            cnt_q <= RESET_WORD[15:0];
            last_q <= 1'b0;
            npend_q <= 4'h0;
            wb_idx_q <= 4'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    // stalls here on an empty ring; the source is held off by ready
                    if (avail)
                    begin
                        mem_o <= '{valid: 1'b1, we: 1'b0, addr: desc_addr(shadow_q),
                            wdata: 64'h0, be: 8'hFF};
                        state_q <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (mem_i.ack)
                    begin
                        mem_o.valid <= 1'b0;
                        buf_addr_q <= mem_i.rdata;
                        cnt_q <= 16'h0000;
                        rx_ready_o <= 1'b1;
                        state_q <= ST_RECV;
                    end
                end
                ST_RECV:
                begin
                    if (rx_i.valid)
                    begin
                        rx_ready_o <= 1'b0;
                        last_q <= rx_i.last;
                        state_q <= ST_STORE;
                        if (!strip_byte)
                        begin
                            mem_o <= '{valid: 1'b1, we: 1'b1, addr: buf_addr_q + {48'h0, cnt_q},
                                wdata: {8{rx_i.data}},
                                be: 8'(8'h01 << ((buf_addr_q[2:0] + cnt_q[2:0]) & 3'h7))};
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                end
                ST_STORE:
                begin
                    if (byte_done)
                    begin
                        mem_o.valid <= 1'b0;
                        if (!close_d)
                        begin
                            rx_ready_o <= 1'b1;
                            state_q <= ST_RECV;
                        end
                        else
                        begin
                            npend_q <= npend_q + 4'h1;
                            if (last_q)
                            begin
                                wb_idx_q <= 4'h0;
                                state_q <= ST_WB;
                                // whole packet is known now, so the first entry can carry the sum
                                mem_o <= '{valid: 1'b1, we: 1'b1,
                                    addr: desc_addr(head_q) + WB_FIELD_OFFSET,
                                    wdata: 64'h0, be: 8'hFF};
                            end
                            else
                            begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_WB:
                begin
                    if (mem_i.ack)
                    begin
                        wb_idx_q <= wb_idx_q + 4'h1;
                        if (wb_idx_q + 4'h1 == npend_q)
                        begin
                            mem_o.valid <= 1'b0;
                            npend_q <= 4'h0;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            mem_o.addr <= desc_addr(head_nxt) + WB_FIELD_OFFSET;
                            mem_o.wdata <= wb_word(wb_idx_q + 4'h1);
                        end
                    end
                    else
                    begin
                        mem_o.wdata <= wb_word(wb_idx_q);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (state_q == ST_STORE && byte_done && close_d)
        begin
            pend_len_q[npend_q[2:0]] <= cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // packet checksum and filter flag, cleared once the packet is written back

    always_ff @(posedge clk_i)
    begin
        if (rst_i || (state_q == ST_WB && mem_i.ack && wb_idx_q + 4'h1 == npend_q))
        begin
            pos_q <= 16'h0000;
            csum_q <= 16'h0000;
            pif_q <= 1'b0;
        end
        else if (state_q == ST_RECV && rx_i.valid)
        begin
            pif_q <= pif_q | rx_i.inexact;
            if (!strip_byte)
            begin
                pos_q <= pos_q + 16'h0001;
                if (pos_q >= {8'h00, csum_start_q})
                begin
                    csum_q <= csum_sum[15:0] + {15'h0000, csum_sum[16]};
                end
            end
        end
    end

endmodule : rx_descriptor_ring_manager

// file: rx_ring_pkg.sv
package rx_ring_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on the wishbone bus
    localparam logic [7:0] REG_BASE_LOW = 8'h00;
    localparam logic [7:0] REG_BASE_HIGH = 8'h04;
    localparam logic [7:0] REG_LENGTH = 8'h08;
    localparam logic [7:0] REG_HEAD = 8'h0C;
    localparam logic [7:0] REG_TAIL = 8'h10;
    localparam logic [7:0] REG_CONTROL = 8'h14;
    localparam logic [7:0] REG_CSUM_CTRL = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_EXT_STATUS = 0;
    localparam int CTRL_DTYP_LO = 1;
    localparam int CTRL_VLAN_STRIP = 3;
    localparam int LEN_LSB = 7;
    localparam int BASE_LSB = 4;
    localparam int STAT_EMPTY = 16;
    localparam int STAT_BUSY = 17;
    localparam int DSTAT_DONE = 0;
    localparam int DSTAT_EOP = 1;
    localparam int DSTAT_IXSM = 2;
    localparam int DSTAT_PIF = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // descriptor geometry and sizes
    localparam logic [1:0] DTYP_LEGACY = 2'h0;
    localparam logic [1:0] DTYP_SPLIT = 2'h1;
    localparam logic [16:0] STEP_LEGACY = 17'h00001;
    localparam logic [16:0] STEP_SPLIT = 17'h00002;
    localparam logic [63:0] WB_FIELD_OFFSET = 64'h0000_0000_0000_0008;
    localparam logic [15:0] BUF_BYTES = 16'h0800;
    localparam int PEND_DEPTH = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic inexact;
        logic vlan_hdr;
    } rx_byte_s;

    typedef struct packed {
        logic valid;
        logic we;
        logic [63:0] addr;
        logic [63:0] wdata;
        logic [7:0] be;
    } mem_req_s;

    typedef struct packed {
        logic ack;
        logic [63:0] rdata;
    } mem_rsp_s;

endpackage : rx_ring_pkg

// file: rx_ring_assertions.sv
`timescale 1ns/10ps
module rx_ring_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire rx_ring_pkg::rx_byte_s rx_i,
    input wire logic rx_ready_o,
    input wire rx_ring_pkg::mem_req_s mem_o,
    input wire rx_ring_pkg::mem_rsp_s mem_i
);
    import rx_ring_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence byte_taken;
        rx_i.valid && rx_ready_o && !rx_i.vlan_hdr;
    endsequence
    sequence wback;
        mem_o.valid && mem_o.we && mem_o.be == 8'hFF;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    wb_answer_a: assert property (wb_req |=> wb_ack_o)
        else $error("register access not acked one cycle later");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("register ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    mem_hold_a: assert property (mem_o.valid && !mem_i.ack |=>
        mem_o.valid && $stable(mem_o.addr) && $stable(mem_o.we))
        else $error("memory request changed before ack");
    fetch_align_a: assert property (mem_o.valid && !mem_o.we |->
        mem_o.addr[3:0] == 4'h0)
        else $error("descriptor fetch not on a 16 byte unit");
    wb_offset_a: assert property (wback |-> mem_o.addr[3:0] == 4'h8)
        else $error("write-back not at descriptor plus 8");
    byte_lane_a: assert property (mem_o.valid && mem_o.we && mem_o.be != 8'hFF |->
        mem_o.be == (8'h01 << mem_o.addr[2:0]))
        else $error("byte lane does not match address");
    byte_store_a: assert property (byte_taken |=> mem_o.valid && mem_o.we)
        else $error("taken byte not stored next cycle");
    ready_drop_a: assert property (rx_i.valid && rx_ready_o |=> !rx_ready_o)
        else $error("ready held after a byte was taken");
    done_status_a: assert property (wback ##0 mem_i.ack |->
        mem_o.wdata[32 + DSTAT_DONE] && mem_o.wdata[32 + DSTAT_IXSM])
        else $error("write-back status lacks done bits");
    // ready may not be raised while the memory side is still busy
    busy_ready_a: assert property (mem_o.valid |-> !rx_ready_o)
        else $error("ready raised during a memory request");
endmodule : rx_ring_assertions
bind rx_descriptor_ring_manager rx_ring_assertions chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i), .rx_ready_o(rx_ready_o),
    .mem_o(mem_o), .mem_i(mem_i));

// file: rx_mem_model.sv
`timescale 1ns/10ps
module rx_mem_model (
    input wire logic clk_i,
    input wire logic [3:0] lag_i,
    input wire rx_ring_pkg::mem_req_s req_i,
    output rx_ring_pkg::mem_rsp_s rsp_o
);
    import rx_ring_pkg::*;
    logic [3:0] wait_q;
    logic [63:0] wb_data_q[$];
    logic [63:0] wb_addr_q[$];
    logic [63:0] rd_addr_q[$];
    int n_bytes;
    initial
    begin
        rsp_o = '0;
        wait_q = 4'h0;
        n_bytes = 0;
    end
    // answers only what is asked; device-owned entries are the only ones touched
    always @(posedge clk_i)
    begin
        rsp_o.ack <= 1'b0;
        // released data lines never show the last value
        rsp_o.rdata <= ~rsp_o.rdata;
        if (req_i.valid && !rsp_o.ack && wait_q < lag_i)
            wait_q <= wait_q + 4'h1;
        else if (req_i.valid && !rsp_o.ack)
        begin
            wait_q <= 4'h0;
            rsp_o.ack <= 1'b1;
            if (!req_i.we)
                rd_addr_q.push_back(req_i.addr);
            if (!req_i.we)
                rsp_o.rdata <= req_i.addr << 8;
            if (req_i.we && req_i.be == 8'hFF)
                wb_data_q.push_back(req_i.wdata);
            if (req_i.we && req_i.be == 8'hFF)
                wb_addr_q.push_back(req_i.addr);
            if (req_i.we && req_i.be != 8'hFF)
                n_bytes++;
        end
    end
endmodule : rx_mem_model

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
    import rx_ring_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_ready_o;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0] wb_sel_i, lag;
    rx_byte_s rx_i;
    mem_req_s mem_o;
    mem_rsp_s mem_i;
    int n_errors = 0;
    int comparisons = 0;
    logic [15:0] e_len, e_sum;
    localparam logic [63:0] BASE = 64'h0000_0001_1000_0000;
    rx_descriptor_ring_manager dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
        .rx_ready_o(rx_ready_o), .mem_o(mem_o), .mem_i(mem_i));
    rx_mem_model mm_u (.clk_i(clk_i), .lag_i(lag), .req_i(mem_o), .rsp_o(mem_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic check(input string n, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        int t;
        t = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (t < 40 && wb_ack_o !== 1'b1);
        if (wb_ack_o !== 1'b1)
        begin
            n_errors++;
            $display("BAD wb ack expected 1 seen %b", wb_ack_o);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] q;
        bus(1'b1, a, d, s, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(n, {32'h0, e}, {32'h0, q});
    endtask : rd
    // expected checksum: ones complement sum over stored bytes from the start offset
    task automatic send(input int n, input int vlo, input int vhi, input logic inx,
        input logic strip, input int start);
        int s;
        logic [31:0] sum;
        logic [7:0] b;
        logic vl;
        s = 0;
        sum = 32'h0;
        for (int i = 0; i < n; i++)
        begin
            b = i[7:0] + 8'h11;
            vl = i >= vlo && i < vhi;
            rx_i <= '{1'b1, b, i == n - 1, inx, vl};
            do
                @(posedge clk_i);
            while (rx_ready_o !== 1'b1);
            if (!(strip && vl) && s >= start)
                sum += (s - start) % 2 == 0 ? {16'h0, b, 8'h00} : {24'h0, b};
            if (!(strip && vl))
                s++;
        end
        rx_i <= '0;
        sum = sum[15:0] + sum[31:16];
        e_sum = sum[15:0] + sum[31:16];
        e_len = s[15:0];
    endtask : send
    task automatic wb_out(input int k, input logic [63:0] a, input logic [7:0] st,
        input logic [15:0] cs, input logic [15:0] ln);
        for (int i = 0; i < 400 && mm_u.wb_data_q.size() < k; i++)
            @(posedge clk_i);
        // let the write-back ack reach the head register before anything reads it
        repeat (3) @(posedge clk_i);
        check("wb addr", a, mm_u.wb_addr_q.pop_front());
        check("wb data", {24'h0, st, cs, ln}, mm_u.wb_data_q.pop_front());
    endtask : wb_out
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // the long packet needs about 8200 cycles; allow nearly five times that
    initial
    begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
    initial
    begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        rx_i = '0;
        lag = 4'h1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 9; a++)
            rd(8'(a * 4), a == 7 ? 32'h0001_0000 : 32'h0, "reset value");
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0, "unmapped");
        wr(REG_BASE_LOW, 32'hFFFF_FFFF);
        rd(REG_BASE_LOW, 32'hFFFF_FFF0, "base low");
        wr(REG_BASE_HIGH, 32'hFFFF_FFFF, 4'h6);
        rd(REG_BASE_HIGH, 32'h00FF_FF00, "base high lanes");
        wr(REG_LENGTH, 32'hFFFF_FFFF);
        rd(REG_LENGTH, 32'h001F_FF80, "length");
        wr(REG_BASE_LOW, 32'h1000_0008);
        wr(REG_BASE_HIGH, 32'h0000_0001);
        wr(REG_LENGTH, 32'h0000_0080);
        repeat (20) @(posedge clk_i);
        check("empty fetch", 64'h0, mm_u.rd_addr_q.size());
        check("empty ready", 64'h0, {63'h0, rx_ready_o});
        wr(REG_TAIL, 32'h2);
        send(2050, 0, 0, 1'b1, 1'b0, 0);
        wb_out(2, BASE + 64'h8, 8'h85, e_sum, 16'h0800);
        wb_out(1, BASE + 64'h18, 8'h87, 16'h0, 16'h0002);
        check("fetch 0", BASE, mm_u.rd_addr_q.pop_front());
        check("fetch 1", BASE + 64'h10, mm_u.rd_addr_q.pop_front());
        check("bytes", 64'd2050, mm_u.n_bytes);
        rd(REG_HEAD, 32'h2, "head");
        rd(REG_STATUS, 32'h0001_0002, "status");
        lag <= 4'h3;
        wr(REG_HEAD, 32'h7);
        wr(REG_TAIL, 32'h0);
        send(3, 0, 0, 1'b0, 1'b0, 0);
        wb_out(1, BASE + 64'h78, 8'h07, e_sum, 16'h0003);
        check("fetch 7", BASE + 64'h70, mm_u.rd_addr_q.pop_front());
        rd(REG_HEAD, 32'h0, "head wrap");
        lag <= 4'h2;
        wr(REG_CONTROL, 32'h0000_000A);
        wr(REG_CSUM_CTRL, 32'h0000_0002);
        // descriptor 0 is handed back; its write-back rewrites the whole status byte
        wr(REG_TAIL, 32'h2);
        rd(REG_STATUS, 32'h0002_0000, "busy fetch");
        send(10, 2, 6, 1'b0, 1'b1, 2);
        wb_out(1, BASE + 64'h8, 8'h07, e_sum, e_len);
        check("split len", 64'd6, {48'h0, e_len});
        check("stripped", 64'd2059, mm_u.n_bytes);
        check("fetches", 64'h1, mm_u.rd_addr_q.size());
        rd(REG_HEAD, 32'h2, "split head");
        close_out();
    end
endmodule : testbench
